//--- rtl/rat_timer_top.sv
`timescale 1ns/10ps
module rat_timer_top
  import rat_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_sys_reset_req,
  output logic o_wake_req,
  output logic o_irq
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  rat_cmp_if cif ();

  logic resp_ff, nxt_resp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic run_ff, nxt_run;
  logic auto_ff, nxt_auto;
  logic [NUM_ALARMS-1:0] aen_ff, nxt_aen;
  logic [TW-1:0] setval_ff, nxt_setval;
  logic [TW-1:0] capt_ff, nxt_capt;
  logic [NUM_ALARMS-1:0][TW-1:0] alarm_ff, nxt_alarm;
  logic [ROUTE_W-1:0] route_ff, nxt_route;
  logic [IRQ_W-1:0] istat_ff, nxt_istat;
  logic [IRQ_W-1:0] imask_ff, nxt_imask;
  logic set_pend_ff, nxt_set_pend;
  logic capt_pend_ff, nxt_capt_pend;
  logic auto_pend_ff, nxt_auto_pend;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic [NUM_ALARMS-1:0] flag_ff, nxt_flag;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic busy;
  logic acc;
  logic wr_ok;
  logic [NUM_ALARMS-1:0] route_rst, route_wake, route_irq;

  // Comparator sees live timer and registered match values
  assign cif.timer = timer_ff;
  assign cif.match = alarm_ff;
  assign cif.en = aen_ff;

  rat_alarm_cmp u_cmp (
    .i_sys_clk (i_sys_clk),
    .i_rst (i_rst),
    .cmp (cif.cmp)
  );

  assign busy = set_pend_ff | capt_pend_ff;
  assign route_rst = route_ff[ROUTE_RST_LSB +: NUM_ALARMS];
  assign route_wake = route_ff[ROUTE_WAKE_LSB +: NUM_ALARMS];
  assign route_irq = route_ff[ROUTE_IRQ_LSB +: NUM_ALARMS];

  // Bus handshake: every access waits exactly one cycle, then completes
  assign acc = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = acc & ~resp_ff;
  assign wr_ok = i_avs_write & resp_ff;
  assign o_avs_readdata = rdata_ff;

  // Event routing; flags are levels so requests hold until software disables
  assign o_sys_reset_req = |(flag_ff & route_rst);
  assign o_wake_req = |(flag_ff & route_wake);
  assign o_irq = |(istat_ff & imask_ff);

  // Tick divider: the slow timer rate as a one-cycle enable
  always_comb begin
    nxt_div = div_ff + DIV_W'(1);
    nxt_tick = 1'b0;
    if (div_ff == DIV_LAST) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
  end

  // Bus answer and read data, captured in the first access cycle
  always_comb begin
    nxt_resp = acc & ~resp_ff;
    nxt_rdata = rdata_ff;
    if (i_avs_read && !resp_ff) begin
      nxt_rdata = 32'h0000_0000;
      case (i_avs_address)
        OFS_CTRL: begin
          nxt_rdata[CTRL_RUN] = run_ff;
          nxt_rdata[CTRL_AUTO] = auto_ff;
          nxt_rdata[CTRL_AEN_LSB +: NUM_ALARMS] = aen_ff;
        end
        OFS_STATUS: begin
          nxt_rdata[ST_FLAG_LSB +: NUM_ALARMS] = flag_ff;
          nxt_rdata[ST_BUSY] = busy;
        end
        OFS_SETVAL: nxt_rdata = setval_ff;
        OFS_CAPT: nxt_rdata = capt_ff;
        OFS_ALARM0: nxt_rdata = alarm_ff[0];
        OFS_ALARM1: nxt_rdata = alarm_ff[1];
        OFS_ALARM2: nxt_rdata = alarm_ff[2];
        OFS_ROUTE: nxt_rdata[ROUTE_W-1:0] = route_ff;
        OFS_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = istat_ff;
        OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = imask_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Timer, transfers, alarm flags and configuration
  always_comb begin
    nxt_run = run_ff;
    nxt_auto = auto_ff;
    nxt_aen = aen_ff;
    nxt_setval = setval_ff;
    nxt_capt = capt_ff;
    nxt_alarm = alarm_ff;
    nxt_route = route_ff;
    nxt_istat = istat_ff;
    nxt_imask = imask_ff;
    nxt_set_pend = set_pend_ff;
    nxt_capt_pend = capt_pend_ff;
    nxt_auto_pend = auto_pend_ff;
    nxt_timer = timer_ff;
    // Timer advances on the tick only while running
    if (tick_ff && run_ff) begin
      if (set_pend_ff) begin
        nxt_timer = setval_ff;
        nxt_set_pend = 1'b0;
      end else if (auto_pend_ff) begin
        nxt_timer = TIMER_RST;
      end else begin
        nxt_timer = timer_ff + TIMER_ONE;
      end
      nxt_auto_pend = 1'b0;
      if (capt_pend_ff) begin
        nxt_capt = timer_ff;
        nxt_capt_pend = 1'b0;
      end
    end
    // Only alarm 0 arms the auto reset for the next tick
    if (cif.ev[0] && auto_ff) begin
      nxt_auto_pend = 1'b1;
    end
    // Register writes; interrupt clear comes before the sets below
    if (wr_ok) begin
      case (i_avs_address)
        OFS_CTRL: begin
          nxt_run = i_avs_writedata[CTRL_RUN];
          nxt_auto = i_avs_writedata[CTRL_AUTO];
          nxt_aen = i_avs_writedata[CTRL_AEN_LSB +: NUM_ALARMS];
          nxt_set_pend = nxt_set_pend | i_avs_writedata[CTRL_SET];
          nxt_capt_pend = nxt_capt_pend | i_avs_writedata[CTRL_CAPT];
        end
        OFS_SETVAL: nxt_setval = i_avs_writedata;
        OFS_ALARM0: nxt_alarm[0] = i_avs_writedata;
        OFS_ALARM1: nxt_alarm[1] = i_avs_writedata;
        OFS_ALARM2: nxt_alarm[2] = i_avs_writedata;
        OFS_ROUTE: nxt_route = i_avs_writedata[ROUTE_W-1:0];
        OFS_IRQ_STAT: nxt_istat = istat_ff & ~i_avs_writedata[IRQ_W-1:0];
        OFS_IRQ_MASK: nxt_imask = i_avs_writedata[IRQ_W-1:0];
        default: nxt_run = run_ff;
      endcase
    end
    // A stopped timer cannot take a transfer, so pending ones are dropped
    if (!nxt_run) begin
      nxt_set_pend = 1'b0;
      nxt_capt_pend = 1'b0;
    end
    // Flag holds while enabled; disabling clears it
    nxt_flag = (flag_ff | cif.ev) & nxt_aen;
    // Sticky interrupt sources; set wins over a same-cycle clear
    nxt_istat[NUM_ALARMS-1:0] = nxt_istat[NUM_ALARMS-1:0] | (cif.ev & route_irq);
    if (tick_ff && run_ff && busy) begin
      nxt_istat[IRQ_XFER] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      resp_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      div_ff <= '0;
      tick_ff <= 1'b0;
      run_ff <= 1'b0;
      auto_ff <= 1'b0;
      aen_ff <= '0;
      setval_ff <= TIMER_RST;
      capt_ff <= TIMER_RST;
      alarm_ff <= '0;
      route_ff <= '0;
      istat_ff <= '0;
      imask_ff <= '0;
      set_pend_ff <= 1'b0;
      capt_pend_ff <= 1'b0;
      auto_pend_ff <= 1'b0;
      timer_ff <= TIMER_RST;
      flag_ff <= '0;
    end else begin
      resp_ff <= nxt_resp;
      rdata_ff <= nxt_rdata;
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      run_ff <= nxt_run;
      auto_ff <= nxt_auto;
      aen_ff <= nxt_aen;
      setval_ff <= nxt_setval;
      capt_ff <= nxt_capt;
      alarm_ff <= nxt_alarm;
      route_ff <= nxt_route;
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
      set_pend_ff <= nxt_set_pend;
      capt_pend_ff <= nxt_capt_pend;
      auto_pend_ff <= nxt_auto_pend;
      timer_ff <= nxt_timer;
      flag_ff <= nxt_flag;
    end
  end

  // Ticks seen while a transfer waits, checked against its bound
  logic [2:0] pend_ticks_ff, nxt_pend_ticks;
  always_comb begin
    nxt_pend_ticks = pend_ticks_ff;
    if (!busy) begin
      nxt_pend_ticks = 3'h0;
    end else if (tick_ff && pend_ticks_ff != 3'h7) begin
      nxt_pend_ticks = pend_ticks_ff + 3'h1; // Saturates, so a stuck transfer stays visible
    end
  end

  // Tick counter register only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pend_ticks_ff <= 3'h0;
    end else begin
      pend_ticks_ff <= nxt_pend_ticks;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_xfer_needs_run: assert property (!run_ff |-> !busy)
    else $error("transfer pending while timer stopped");
  a_xfer_bound: assert property (pend_ticks_ff <= 3'h2)
    else $error("transfer took more than two ticks");
  a_auto_clear: assert property (tick_ff && run_ff && auto_pend_ff && !set_pend_ff |=> timer_ff == TIMER_RST)
    else $error("auto reset did not clear timer");
  a_only_alarm0: assert property ($rose(auto_pend_ff) |-> $past(cif.ev[0] && auto_ff))
    else $error("auto reset armed without alarm 0");
  a_flag_clear: assert property (1'b1 |=> (flag_ff & ~$past(aen_ff)) == '0)
    else $error("flag survived disable");
  a_flag_hold: assert property (flag_ff[2] && aen_ff[2] && !(wr_ok && i_avs_address == OFS_CTRL) |=> flag_ff[2])
    else $error("alarm 2 flag dropped while enabled");
  a_wrap_zero: assert property (tick_ff && run_ff && timer_ff == TIMER_MAX && !busy && !auto_pend_ff
      |=> timer_ff == TIMER_RST)
    else $error("timer did not wrap to zero");
  a_count_up: assert property (tick_ff && run_ff && !set_pend_ff && !auto_pend_ff
      |=> timer_ff == $past(timer_ff) + TIMER_ONE)
    else $error("timer did not advance by one");
  a_irq_route: assert property (cif.ev[0] && route_irq[0] |=> istat_ff[0] ##0 (o_irq || !imask_ff[0]))
    else $error("routed alarm did not raise interrupt");
  a_timer_still: assert property (!(tick_ff && run_ff) |=> $stable(timer_ff))
    else $error("timer moved without tick");

  // Transfer results land at the serving tick
  a_set_load: assert property (tick_ff && run_ff && set_pend_ff |=> timer_ff == $past(setval_ff))
    else $error("set did not load timer");
  a_capt_value: assert property (tick_ff && run_ff && capt_pend_ff |=> capt_ff == $past(timer_ff))
    else $error("capture did not hold timer value");
  a_xfer_done: assert property (tick_ff && run_ff && busy |=> istat_ff[IRQ_XFER])
    else $error("transfer done not flagged");

  // Routing and sticky state; bus writes excluded since they may legally change both
  a_flag_set: assert property (cif.ev[1] && !wr_ok |=> flag_ff[1])
    else $error("alarm 1 flag not set");
  a_wake_route: assert property (cif.ev[0] && route_wake[0] && !wr_ok |=> o_wake_req)
    else $error("routed alarm did not request wake");
  a_reset_route: assert property (cif.ev[0] && route_rst[0] && !wr_ok |=> o_sys_reset_req)
    else $error("routed alarm did not request reset");
  a_irq_sticky: assert property (istat_ff[0] && !(wr_ok && i_avs_address == OFS_IRQ_STAT) |=> istat_ff[0])
    else $error("interrupt status dropped without clear");
  a_alarm1_no_reset: assert property (cif.ev[1] && !cif.ev[0] && !auto_pend_ff |=> !auto_pend_ff)
    else $error("alarm 1 armed the auto reset");
endmodule

//--- rtl/rat_pkg.sv
package rat_pkg;
  // Block shape
  localparam int NUM_ALARMS = 3;
  localparam int TW = 32;
  localparam int ADDR_W = 6;
  // Clock rates, timer tick derived from them
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 32768;
  localparam int TICK_DIV = SYS_CLK_HZ / TICK_HZ;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_SETVAL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPT = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_ALARM0 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_ALARM1 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_ALARM2 = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h24;
  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_AEN_LSB = 2;
  localparam int CTRL_SET = 5;
  localparam int CTRL_CAPT = 6;
  // Status field positions
  localparam int ST_FLAG_LSB = 0;
  localparam int ST_BUSY = 3;
  // Routing field positions, one bit per alarm in each group
  localparam int ROUTE_RST_LSB = 0;
  localparam int ROUTE_WAKE_LSB = 3;
  localparam int ROUTE_IRQ_LSB = 6;
  localparam int ROUTE_W = 9;
  // Interrupt status: alarms in bits 0..2, transfer done in bit 3
  localparam int IRQ_XFER = 3;
  localparam int IRQ_W = 4;
  // Timer reset value, maximum and increment
  localparam logic [TW-1:0] TIMER_RST = 32'h0000_0000;
  localparam logic [TW-1:0] TIMER_MAX = 32'hffff_ffff;
  localparam logic [TW-1:0] TIMER_ONE = 32'h0000_0001;
endpackage

//--- rtl/rat_cmp_if.sv
`timescale 1ns/10ps
interface rat_cmp_if;
  import rat_pkg::*;
  logic [TW-1:0] timer;
  logic [NUM_ALARMS-1:0][TW-1:0] match;
  logic [NUM_ALARMS-1:0] en;
  logic [NUM_ALARMS-1:0] ev;
  modport core (output timer, output match, output en, input ev);
  modport cmp (input timer, input match, input en, output ev);
endinterface

//--- rtl/rat_alarm_cmp.sv
`timescale 1ns/10ps
module rat_alarm_cmp
  import rat_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  rat_cmp_if.cmp cmp
);
  logic [NUM_ALARMS-1:0] match_now;
  logic [NUM_ALARMS-1:0] match_q_ff;
  logic [NUM_ALARMS-1:0] nxt_match_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Full-width equality per alarm; only the rising edge is an event
  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g++) begin : g_cmp
      assign match_now[g] = (cmp.timer == cmp.match[g]);
      // Edge, not level: re-enabling on a standing match waits for the wrap
      assign cmp.ev[g] = cmp.en[g] & match_now[g] & ~match_q_ff[g];
    end
  endgenerate

  // Previous match state
  always_comb begin
    nxt_match_q = match_now;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      match_q_ff <= '0;
    end else begin
      match_q_ff <= nxt_match_q;
    end
  end

  a_exact_match: assert property (cmp.ev[0] |-> cmp.timer == cmp.match[0])
    else $error("alarm 0 event without exact match");
  a_full_compare: assert property ($rose(match_now[1]) && cmp.en[1] |-> cmp.ev[1])
    else $error("alarm 1 match missed");
endmodule

//--- tb/test_rtc_alarm_timer.sv
`timescale 1ns/10ps
module test_rtc_alarm_timer
  import rat_pkg::*;
;
  localparam int TICKS = 4;
  logic i_sys_clk;
  logic i_rst;
  logic [ADDR_W-1:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_sys_reset_req;
  logic o_wake_req;
  logic o_irq;
  int n_mismatch;
  int check_count;
  int cyc;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] hi;
  int q_exp[$];
  int n_ev;

  // Short tick so alarms land within a few hundred cycles
  rat_timer_top #(.TICK_CYCLES(TICKS)) dut (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_sys_reset_req(o_sys_reset_req),
    .o_wake_req(o_wake_req),
    .o_irq(o_irq)
  );

  // Clock, 4 ns period
  always #2 i_sys_clk = ~i_sys_clk;

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= ~w;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  // Bounded status poll, leaves the last read in rd
  task automatic poll(input int b, input logic val);
    int n;
    n = 0;
    do begin
      bus(OFS_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[b] !== val && n < 100);
  endtask

  task automatic capture();
    bus(OFS_CTRL, 1'b1, 32'h41);
    poll(ST_BUSY, 1'b0);
    bus(OFS_CAPT, 1'b0, 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    i_rst = 1'b1;
    i_avs_address = '0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(32'h4343764d));
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // Reset values and an unmapped place
    bus(OFS_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(6'h3c, 1'b1, 32'hffff_ffff);
    bus(6'h3c, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(OFS_ROUTE, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // Set while stopped must be dropped
    bus(OFS_SETVAL, 1'b1, 32'h00ab_0000);
    bus(OFS_CTRL, 1'b1, 32'h20);
    bus(OFS_CTRL, 1'b1, 32'h01);
    capture();
    chk({31'h0, rd < 32'h0001_0000}, 32'h1);
    $display("test stopped set done");
    // Set then capture, random values and one next to wrap
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? TIMER_MAX - TIMER_ONE : $urandom;
      bus(OFS_SETVAL, 1'b1, v);
      bus(OFS_CTRL, 1'b1, 32'h21);
      poll(ST_BUSY, 1'b0);
      chk(rd[ST_BUSY], 1'b0);
      capture();
      chk({31'h0, (rd - v) <= 32'h8}, 32'h1);
    end
    $display("test set capture done");
    // Free run across wrap, alarm 0 just past zero, alarm 1 behind timer
    bus(OFS_ROUTE, 1'b1, 32'h49);
    bus(OFS_IRQ_MASK, 1'b1, 32'hf);
    bus(OFS_IRQ_STAT, 1'b1, 32'hf);
    bus(OFS_ALARM0, 1'b1, TIMER_ONE);
    bus(OFS_ALARM1, 1'b1, TIMER_MAX - 32'h40);
    bus(OFS_SETVAL, 1'b1, TIMER_MAX - 32'h3);
    bus(OFS_CTRL, 1'b1, 32'h21);
    poll(ST_BUSY, 1'b0);
    bus(OFS_IRQ_STAT, 1'b1, 32'hf);
    bus(OFS_CTRL, 1'b1, 32'h0d);
    q_exp.push_back(1);
    poll(ST_FLAG_LSB, 1'b1);
    chk(rd, q_exp.pop_front());
    repeat (20) @(posedge i_sys_clk);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    @(posedge i_sys_clk);
    chk({29'h0, o_sys_reset_req, o_wake_req, o_irq}, 32'h7);
    // Disable clears flag; interrupt stays sticky until masked and cleared
    bus(OFS_CTRL, 1'b1, 32'h01);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    @(posedge i_sys_clk);
    chk({29'h0, o_sys_reset_req, o_wake_req, o_irq}, 32'h1);
    bus(OFS_IRQ_MASK, 1'b1, 32'h0);
    @(posedge i_sys_clk);
    chk({31'h0, o_irq}, 32'h0);
    bus(OFS_IRQ_STAT, 1'b1, 32'hf);
    bus(OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // Re-enable on unchanged match: no event before a full wrap
    bus(OFS_CTRL, 1'b1, 32'h05);
    repeat (60) @(posedge i_sys_clk);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // Advance alarm 1 by an interval; the 32-bit sum wraps just as the timer does
    v = TIMER_MAX - 32'h40;
    v = v + 32'h80;
    bus(OFS_CTRL, 1'b1, 32'h01);
    bus(OFS_ALARM1, 1'b1, v);
    bus(OFS_CTRL, 1'b1, 32'h09);
    poll(ST_FLAG_LSB + 1, 1'b1);
    chk(rd, 32'h2);
    $display("test free alarm done");
    // Auto reset: alarm 0 at 6 bounds the timer, alarms 1 at 3 and 2 at 5 do not
    bus(OFS_CTRL, 1'b1, 32'h0);
    bus(OFS_ALARM0, 1'b1, 32'h6);
    bus(OFS_ALARM1, 1'b1, 32'h3);
    bus(OFS_ALARM2, 1'b1, 32'h5);
    bus(OFS_SETVAL, 1'b1, 32'h0);
    bus(OFS_CTRL, 1'b1, 32'h21);
    poll(ST_BUSY, 1'b0);
    bus(OFS_CTRL, 1'b1, 32'h1f);
    poll(ST_FLAG_LSB + 1, 1'b1);
    poll(ST_FLAG_LSB, 1'b1);
    chk(rd[2:0], 3'h7);
    hi = 32'h0;
    n_ev = 0;
    for (int i = 0; i < 16; i++) begin
      bus(OFS_CTRL, 1'b1, 32'h5f);
      poll(ST_BUSY, 1'b0);
      bus(OFS_CAPT, 1'b0, 32'h0);
      chk({31'h0, rd <= 32'h6}, 32'h1);
      if (rd > hi) hi = rd;
      // Software keeps time by counting alarm 0 events itself
      bus(OFS_IRQ_STAT, 1'b0, 32'h0);
      if (rd[0] === 1'b1) begin
        n_ev++;
        bus(OFS_IRQ_STAT, 1'b1, 32'h1);
      end
    end
    chk({31'h0, hi > 32'h3}, 32'h1);
    chk({31'h0, n_ev >= 4}, 32'h1);
    $display("test auto reset done");
    conclude();
  end
endmodule
